/* design/msa_step10_params.svh */
`ifndef MSA_STEP10_PARAMS_SVH
`define MSA_STEP10_PARAMS_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define MSA_STEP10_CFG_ADDR    8'h9a
`define MSA_STEP10_CFG_RESET   16'h000a
`define MSA_STEP10_CFG_WMASK   16'he01f

// ----------------------------------------
// field positions
// ----------------------------------------
`define MSA_EN_BIT             15
`define MSA_GAIN_HI            14
`define MSA_GAIN_LO            13
`define MSA_NEG_BIT            4
`define MSA_POS_HI             3
`define MSA_POS_LO             0
`define MSA_RSV_HI             12
`define MSA_RSV_LO             5
`define MSA_STEP_INDEX         4'ha

// ----------------------------------------
// positive input codes
// ----------------------------------------
`define MSA_POS_EXT_LAST       4'h7
`define MSA_POS_TEMP           4'h8
`define MSA_POS_SHORT          4'h9
`define MSA_POS_TDAC           4'ha
`define MSA_POS_CODE_B         4'hb
`define MSA_POS_SUP4_A         4'hc
`define MSA_POS_SUP4_B         4'hd
`define MSA_POS_SUP103_A       4'he
`define MSA_POS_SUP103_B       4'hf

`endif

/* design/msa_step10_pkg.sv */
package msa_step10_pkg;

    typedef enum logic [2:0] {
        MSA_GAIN_X1 = 3'b001,
        MSA_GAIN_X2 = 3'b010,
        MSA_GAIN_X4 = 3'b100
    } msa_gain_e;

    typedef enum logic [1:0] {
        MSA_NEG_AGND = 2'b01,
        MSA_NEG_EXT7 = 2'b10
    } msa_neg_e;

    typedef struct packed {
        logic       stepEnable;
        msa_gain_e  gain;
        logic [3:0] posSel;
        logic       negAuto;
        msa_neg_e   negSel;
    } msa_step_cfg_s;

    typedef struct packed {
        logic       wrEn;
        logic       rdEn;
        logic [7:0] addr;
        logic [15:0] wdata;
    } msa_reg_req_s;

endpackage

/* design/msa_step10_decode.sv */
`timescale 1ns/10ps
`default_nettype none
`include "msa_step10_params.svh"

module msa_step10_decode (
    // raw register
    input  wire logic [15:0]                   cfgReg,
    // decoded selection
    output var msa_step10_pkg::msa_step_cfg_s  cfgDec
);

    wire logic [1:0] gainField = cfgReg[`MSA_GAIN_HI:`MSA_GAIN_LO];
    wire logic [3:0] posField  = cfgReg[`MSA_POS_HI:`MSA_POS_LO];
    // any code above the external range picks the negative input itself
    wire logic       negAuto   = (posField > `MSA_POS_EXT_LAST);
    // bit 4 masked when auto
    wire logic       negExt    = !negAuto && cfgReg[`MSA_NEG_BIT];
    msa_step10_pkg::msa_gain_e gainDec;
    msa_step10_pkg::msa_neg_e  negDec;

    assign gainDec = (gainField == 2'h0) ? msa_step10_pkg::MSA_GAIN_X1 :
                     (gainField == 2'h1) ? msa_step10_pkg::MSA_GAIN_X2 :
                                           msa_step10_pkg::MSA_GAIN_X4;
    assign negDec  = negExt ? msa_step10_pkg::MSA_NEG_EXT7 :
                              msa_step10_pkg::MSA_NEG_AGND;
    assign cfgDec  = '{stepEnable: cfgReg[`MSA_EN_BIT], gain: gainDec, posSel: posField,
                       negAuto: negAuto, negSel: negDec};

endmodule
`default_nettype wire

/* design/msa_step10_cfg.sv */
// Functional notes
// - bit 15 enables step 10; zero leaves it out of the sequence.
// - bits 14:13 gain; 00 is x1, 01 is x2, 10 and 11 are x4.
// - bits 12:5 are reserved, read-only and always read zero.
// - bit 4 picks negative input: 0 analog ground, 1 external input 7.
// - bits 3:0 positive input; codes 0 to 7 pick external inputs 0 to 7.
// - codes 8,9,10 pick temperature, internal short, test DAC; auto negative.
// - codes 12,13 supply over 4; 14,15 supply over 103; auto negative.
// - with automatic negative selection the negative select bit is ignored.
// - register at address 9Ah, reset value 000Ah.
`timescale 1ns/10ps
`default_nettype none
`include "msa_step10_params.svh"

module msa_step10_cfg (
    // clock and reset
    input  wire logic                          core_clk,
    input  wire logic                          nrst,
    // register port
    input  wire msa_step10_pkg::msa_reg_req_s  regReq,
    output logic [15:0]                        regRdata,
    output logic                               regRvalid,
    // sequencer side
    input  wire logic                          stepStart,
    input  wire logic [3:0]                    stepIndex,
    output var msa_step10_pkg::msa_step_cfg_s  stepCfg,
    output logic                               stepActive
);

    // ----------------------------------------
    // register storage
    // ----------------------------------------
    logic [15:0] cfg_q;
    logic [15:0] cfg_d;
    logic [15:0] rdata_q;
    logic        rvalid_q;
    logic        active_q;
    msa_step10_pkg::msa_step_cfg_s applied_q;
    msa_step10_pkg::msa_step_cfg_s cfgDec;

    // ----------------------------------------
    // address and mask helpers
    // ----------------------------------------
    // one compare shared by the write and the read strobe
    function automatic logic isCfgAddr(input logic [7:0] addr);
        isCfgAddr = (addr == `MSA_STEP10_CFG_ADDR);
    endfunction

    // reserved bits are cut on the way in and on the way out alike
    function automatic logic [15:0] keepWritable(input logic [15:0] word);
        keepWritable = word & `MSA_STEP10_CFG_WMASK;
    endfunction

    // ----------------------------------------
    // strobe decode
    // ----------------------------------------
    wire logic hit      = isCfgAddr(regReq.addr);
    wire logic wrHit    = regReq.wrEn && hit;
    wire logic rdHit    = regReq.rdEn && hit;
    // reserved bits never store, so they read back zero
    assign cfg_d = wrHit ? keepWritable(regReq.wdata) : cfg_q;
    wire logic visit10  = stepStart && (stepIndex == `MSA_STEP_INDEX);
    // a write mid-conversion waits for the next step-10 start
    wire logic enter10  = visit10 && cfg_q[`MSA_EN_BIT];

    msa_step10_decode u_decode (
        .cfgReg (cfg_q),
        .cfgDec (cfgDec)
    );

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cfg_q <= `MSA_STEP10_CFG_RESET;
        end else begin
            cfg_q <= cfg_d;
        end
    end

    // ----------------------------------------
    // read path
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rdata_q  <= 16'h0000;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= rdHit;
            rdata_q  <= rdHit ? keepWritable(cfg_q) : 16'h0000;
        end
    end

    // ----------------------------------------
    // step application
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            active_q  <= 1'b0;
            applied_q <= '{stepEnable: 1'b0, gain: msa_step10_pkg::MSA_GAIN_X1,
                           posSel: `MSA_POS_TDAC, negAuto: 1'b1,
                           negSel: msa_step10_pkg::MSA_NEG_AGND};
        end else begin
            if (stepStart) begin
                active_q <= enter10;
            end
            if (enter10) begin
                applied_q <= cfgDec;
            end
        end
    end

    assign regRdata   = rdata_q;
    assign regRvalid  = rvalid_q;
    assign stepCfg    = applied_q;
    assign stepActive = active_q;

    // ----------------------------------------
    // register bus checks
    // ----------------------------------------
    AST_RESERVED_ZERO: assert property (@(posedge core_clk) disable iff (!nrst)
        regRvalid |-> regRdata[`MSA_RSV_HI:`MSA_RSV_LO] == 8'h00)
        else $error("reserved bits read nonzero");

    // storage itself stays clean, not only the read mux
    AST_RSV_NEVER_STORED: assert property (@(posedge core_clk) disable iff (!nrst)
        cfg_q[`MSA_RSV_HI:`MSA_RSV_LO] == 8'h00)
        else $error("reserved bits stored");

    AST_WRITE_READBACK: assert property (@(posedge core_clk) disable iff (!nrst)
        (wrHit && !regReq.rdEn) ##1 rdHit |=>
        regRdata == ($past(regReq.wdata, 2) & `MSA_STEP10_CFG_WMASK))
        else $error("readback mismatch");

    AST_READ_ANSWER: assert property (@(posedge core_clk) disable iff (!nrst)
        rdHit |=> regRvalid)
        else $error("mapped read not answered");

    // the bus sees zero between answers, so a stale word is never taken for data
    AST_NO_STRAY_ANSWER: assert property (@(posedge core_clk) disable iff (!nrst)
        !rdHit |=> !regRvalid && regRdata == 16'h0000)
        else $error("answer without mapped read");

    // a write to any other address must leave this word alone
    AST_NO_STORE_OFF_ADDR: assert property (@(posedge core_clk) disable iff (!nrst)
        !wrHit |=> $stable(cfg_q))
        else $error("register changed without mapped write");

    // ----------------------------------------
    // selection checks
    // ----------------------------------------
    AST_ENABLE_APPLIED: assert property (@(posedge core_clk) disable iff (!nrst)
        enter10 |=> stepCfg.stepEnable)
        else $error("applied step not enabled");

    AST_GAIN_X1: assert property (@(posedge core_clk) disable iff (!nrst)
        enter10 && cfg_q[`MSA_GAIN_HI:`MSA_GAIN_LO] == 2'h0 |=>
        stepCfg.gain == msa_step10_pkg::MSA_GAIN_X1)
        else $error("gain not x1");

    AST_GAIN_X2: assert property (@(posedge core_clk) disable iff (!nrst)
        enter10 && cfg_q[`MSA_GAIN_HI:`MSA_GAIN_LO] == 2'h1 |=>
        stepCfg.gain == msa_step10_pkg::MSA_GAIN_X2)
        else $error("gain not x2");

    // codes 10 and 11 both give x4, so only the upper bit matters
    AST_GAIN_DECODE: assert property (@(posedge core_clk) disable iff (!nrst)
        enter10 && cfg_q[`MSA_GAIN_HI] |=> stepCfg.gain == msa_step10_pkg::MSA_GAIN_X4)
        else $error("gain not x4");

    AST_NEG_AGND: assert property (@(posedge core_clk) disable iff (!nrst)
        enter10 && !cfg_q[`MSA_POS_HI] && !cfg_q[`MSA_NEG_BIT] |=>
        stepCfg.negSel == msa_step10_pkg::MSA_NEG_AGND)
        else $error("negative input not analog ground");

    AST_NEG_EXT: assert property (@(posedge core_clk) disable iff (!nrst)
        enter10 && !cfg_q[`MSA_POS_HI] && cfg_q[`MSA_NEG_BIT] |=>
        stepCfg.negSel == msa_step10_pkg::MSA_NEG_EXT7)
        else $error("negative input not external 7");

    AST_POS_PASS: assert property (@(posedge core_clk) disable iff (!nrst)
        enter10 |=> stepCfg.posSel == $past(cfg_q[`MSA_POS_HI:`MSA_POS_LO]))
        else $error("positive select mismatch");

    AST_EXT_CODES: assert property (@(posedge core_clk) disable iff (!nrst)
        enter10 && !cfg_q[`MSA_POS_HI] |=> !stepCfg.negAuto)
        else $error("external code took automatic negative");

    // code 11 is undocumented; it is treated as automatic like its neighbours
    AST_AUTO_CODES: assert property (@(posedge core_clk) disable iff (!nrst)
        enter10 && cfg_q[`MSA_POS_HI:`MSA_POS_LO] > `MSA_POS_EXT_LAST |=> stepCfg.negAuto)
        else $error("auto negative missing");

    AST_SUPPLY_CODES: assert property (@(posedge core_clk) disable iff (!nrst)
        enter10 && cfg_q[3:2] == 2'h3 |=> stepCfg.negAuto && stepCfg.posSel[3:2] == 2'h3)
        else $error("supply code mishandled");

    // bit 4 must not leak through once the code picks the negative input
    AST_NEG_AUTO: assert property (@(posedge core_clk) disable iff (!nrst)
        enter10 && cfg_q[`MSA_POS_HI] |=>
        stepCfg.negAuto && stepCfg.negSel == msa_step10_pkg::MSA_NEG_AGND)
        else $error("negative select not ignored");

    // ----------------------------------------
    // step timing checks
    // ----------------------------------------
    AST_ENABLE_GATES: assert property (@(posedge core_clk) disable iff (!nrst)
        visit10 |=> stepActive == $past(cfg_q[`MSA_EN_BIT]))
        else $error("step active disagrees with enable");

    AST_ACTIVE_HOLD: assert property (@(posedge core_clk) disable iff (!nrst)
        !stepStart |=> $stable(stepActive))
        else $error("step active moved without a step start");

    // the sequencer may look at the selection any time, so it only moves on entry
    AST_HOLD_OUTSIDE: assert property (@(posedge core_clk) disable iff (!nrst)
        !enter10 |=> $stable(stepCfg))
        else $error("config changed outside step 10 entry");

    // ----------------------------------------
    // coverage
    // ----------------------------------------
    COV_WRITE: cover property (@(posedge core_clk) disable iff (!nrst) wrHit);
    COV_READ: cover property (@(posedge core_clk) disable iff (!nrst) rdHit ##1 regRvalid);
    COV_ENTER: cover property (@(posedge core_clk) disable iff (!nrst) enter10);
    COV_WRITE_MID: cover property (@(posedge core_clk) disable iff (!nrst)
        stepActive && wrHit ##[1:20] enter10);
    COV_AUTO_NEG: cover property (@(posedge core_clk) disable iff (!nrst)
        enter10 && cfg_q[`MSA_POS_HI] && cfg_q[`MSA_NEG_BIT]);

endmodule
`default_nettype wire

/* tb/msa_step10_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, a) begin num_checks++; if ((a) !== (e)) begin n_errors++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, a); end end

module tb;
    // ----------------------------------------
    // signals and table
    // ----------------------------------------
    typedef struct {
        logic [15:0] wd;
        logic [15:0] rd;
        logic [2:0]  g;
        logic        au;
        logic [1:0]  ng;
    } msa_row_s;
    logic                         core_clk = 1'b0;
    logic                         nrst = 1'b0;
    msa_step10_pkg::msa_reg_req_s regReq = '0;
    logic [15:0]                  regRdata;
    logic                         regRvalid;
    logic                         stepStart = 1'b0;
    logic [3:0]                   stepIndex = 4'h0;
    msa_step10_pkg::msa_step_cfg_s stepCfg;
    logic                         stepActive;
    int                           n_errors = 0;
    int                           num_checks = 0;
    msa_row_s rows [11] = '{'{16'h8000, 16'h8000, 3'h1, 1'h0, 2'h1},
        '{16'ha017, 16'ha017, 3'h2, 1'h0, 2'h2}, '{16'hc013, 16'hc013, 3'h4, 1'h0, 2'h2},
        '{16'he005, 16'he005, 3'h4, 1'h0, 2'h1}, '{16'h8018, 16'h8018, 3'h1, 1'h1, 2'h0},
        '{16'hfff9, 16'he019, 3'h4, 1'h1, 2'h0}, '{16'h800a, 16'h800a, 3'h1, 1'h1, 2'h0},
        '{16'h801c, 16'h801c, 3'h1, 1'h1, 2'h0}, '{16'ha00d, 16'ha00d, 3'h2, 1'h1, 2'h0},
        '{16'h800e, 16'h800e, 3'h1, 1'h1, 2'h0}, '{16'hffff, 16'he01f, 3'h4, 1'h1, 2'h0}};

    always #5 core_clk = ~core_clk;

    msa_step10_cfg i_dut (.core_clk(core_clk), .nrst(nrst), .regReq(regReq),
        .regRdata(regRdata), .regRvalid(regRvalid), .stepStart(stepStart),
        .stepIndex(stepIndex), .stepCfg(stepCfg), .stepActive(stepActive));

    // ----------------------------------------
    // bus and step tasks
    // ----------------------------------------
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge core_clk) regReq <= '{1'b1, 1'b0, a, d};
        @(posedge core_clk) regReq <= '0;
    endtask
    // read answer stands one cycle only, so it is sampled just after that edge
    task automatic rd(input logic [7:0] a, input logic v, input logic [15:0] d);
        @(posedge core_clk) regReq <= '{1'b0, 1'b1, a, 16'h0000};
        @(posedge core_clk) regReq <= '0;
        #1;
        `CHK("regRvalid", v, regRvalid)
        `CHK("regRdata", d, regRdata)
    endtask
    task automatic step(input logic [3:0] i, input logic act);
        @(posedge core_clk) begin
            stepStart <= 1'b1;
            stepIndex <= i;
        end
        @(posedge core_clk) stepStart <= 1'b0;
        #1;
        `CHK("stepActive", act, stepActive)
    endtask

    task automatic results;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        #100000;
        n_errors++;
        results();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
        `CHK("rstPos", 4'ha, stepCfg.posSel)
        `CHK("rstEn", 1'b0, stepCfg.stepEnable)
        rd(8'h9a, 1'b1, 16'h000a);
        step(4'ha, 1'b0);
        $display("test reset done");
        foreach (rows[k]) begin
            wr(8'h9a, rows[k].wd);
            rd(8'h9a, 1'b1, rows[k].rd);
            step(4'ha, 1'b1);
            `CHK("gain", rows[k].g, stepCfg.gain)
            `CHK("posSel", rows[k].wd[3:0], stepCfg.posSel)
            `CHK("negAuto", rows[k].au, stepCfg.negAuto)
            `CHK("enable", 1'b1, stepCfg.stepEnable)
            if (!rows[k].au) begin
                `CHK("negSel", rows[k].ng, stepCfg.negSel)
            end else begin
                `CHK("negIgnored", 2'h1, stepCfg.negSel)
            end
            $display("test row %0d done", k);
        end
        // write in mid-step waits for the next visit
        wr(8'h9a, 16'h8013);
        `CHK("midPos", 4'hf, stepCfg.posSel)
        step(4'hb, 1'b0);
        `CHK("otherPos", 4'hf, stepCfg.posSel)
        step(4'ha, 1'b1);
        `CHK("nextPos", 4'h3, stepCfg.posSel)
        `CHK("nextNeg", 2'h2, stepCfg.negSel)
        $display("test mid-step done");
        // disabled step keeps old selection
        wr(8'h9a, 16'h0015);
        step(4'ha, 1'b0);
        `CHK("disPos", 4'h3, stepCfg.posSel)
        $display("test disable done");
        // unmapped address neither stores nor answers
        wr(8'h9b, 16'hffff);
        rd(8'h9b, 1'b0, 16'h0000);
        rd(8'h9a, 1'b1, 16'h0015);
        $display("test unmapped done");
        // write then read on back-to-back cycles, with the undocumented code
        @(posedge core_clk) regReq <= '{1'b1, 1'b0, 8'h9a, 16'h801b};
        @(posedge core_clk) regReq <= '{1'b0, 1'b1, 8'h9a, 16'h0000};
        @(posedge core_clk) regReq <= '0;
        #1;
        `CHK("b2bValid", 1'b1, regRvalid)
        `CHK("b2bRdata", 16'h801b, regRdata)
        step(4'ha, 1'b1);
        `CHK("codeBAuto", 1'b1, stepCfg.negAuto)
        `CHK("codeBNeg", 2'h1, stepCfg.negSel)
        $display("test back-to-back done");
        // second reset in mid-run
        @(posedge core_clk) nrst <= 1'b0;
        @(posedge core_clk) nrst <= 1'b1;
        `CHK("rst2Pos", 4'ha, stepCfg.posSel)
        `CHK("rst2Active", 1'b0, stepActive)
        rd(8'h9a, 1'b1, 16'h000a);
        $display("test second reset done");
        results();
    end
endmodule
`default_nettype wire
